// File: hw/pae_pkg.sv
// Purpose: constants and types shared by the pattern sequencer with error injection
// Assumes: 32-bit word leaves per mclk cycle, so 4 words form a 128-bit block
// Notes: pattern lengths counted in 512-bit units of 16 words
package pae_pkg;
   localparam int WORD_W = 32;
   localparam int MEM_AW = 12;
   localparam int MEM_WORDS = 4096;
   localparam logic [7:0] CHUNK_WORDS_LOG2 = 8'h04; // 512 bits = 16 words
   localparam logic [31:0] BITS_PER_WORD = 32'h0000_0020;
   // register byte addresses
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_CMD = 8'h04;
   localparam logic [7:0] REG_RATE = 8'h08;
   localparam logic [7:0] REG_AVG = 8'h0c;
   localparam logic [7:0] REG_LEN = 8'h10;
   localparam logic [7:0] REG_MADDR = 8'h14;
   localparam logic [7:0] REG_MDATA = 8'h18;
   localparam logic [7:0] REG_STAT = 8'h1c;
   // reset values
   localparam logic [31:0] AVG_RST = 32'h0000_03e8;
   localparam logic [7:0] LEN_RST = 8'h01;
   typedef enum logic [1:0] {
      SRC_OFF = 2'b00, SRC_EXT = 2'b01, SRC_INT = 2'b10
   } pae_src_e;
   typedef enum logic [1:0] {
      SEQ_CONT_A = 2'b00, SEQ_CONT_B = 2'b01, SEQ_ALT = 2'b10, SEQ_SHOT_B = 2'b11
   } pae_seq_e;
   typedef enum logic [1:0] {
      AUX_DISABLE = 2'b00, AUX_LEVEL = 2'b01, AUX_EDGE = 2'b10, AUX_BLANK = 2'b11
   } pae_aux_e;
   typedef enum logic [1:0] {
      CH_DATA = 2'b00, CH_AUX = 2'b01, CH_BOTH = 2'b10
   } pae_chan_e;
   // control register layout, high bit first
   typedef struct packed {
      logic [19:0] rsvd;
      pae_aux_e aux_mode;    // [11:10]
      pae_seq_e seq_mode;    // [9:8]
      logic alt_pattern;     // [7]
      logic single_ch;       // [6]
      pae_chan_e chan;       // [5:4]
      logic rate_avg;        // [3]
      pae_src_e src;         // [2:1]
      logic out_en;          // [0]
   } pae_ctrl_s;
   // one stream stage: word metadata travelling with the memory read
   typedef struct packed {
      logic valid;
      logic blank;
      logic [WORD_W-1:0] flip;
   } pae_stage_s;
   // preset error interval: index 0 = 1.000E-02 ... 7 = 1.000E-09
   function automatic logic [31:0] preset_interval(input logic [2:0] idx);
      case (idx)
         3'h0: preset_interval = 32'h0000_0064;
         3'h1: preset_interval = 32'h0000_03e8;
         3'h2: preset_interval = 32'h0000_2710;
         3'h3: preset_interval = 32'h0001_86a0;
         3'h4: preset_interval = 32'h000f_4240;
         3'h5: preset_interval = 32'h0098_9680;
         3'h6: preset_interval = 32'h05f5_e100;
         default: preset_interval = 32'h3b9a_ca00;
      endcase
   endfunction
endpackage

// File: hw/pae_rate_gen.sv
// Purpose: internal error rate generator, one tick per interval of bits
// Assumes: BITS_PER_WORD bits leave each enabled cycle
// Notes: fractional remainder carried so long-run ratio is exact
`timescale 1ns/1ps
module pae_rate_gen
   import pae_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic en,
   input wire logic [31:0] interval,
   output logic tick
);
   logic [32:0] acc;
   logic [32:0] next_acc;
   logic [32:0] ivl;

   // bit accumulator against the interval
   always_comb begin
      ivl = {1'b0, interval};
      next_acc = acc + {1'b0, BITS_PER_WORD};
      tick = en && (next_acc >= ivl);
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         acc <= 33'h0_0000_0000;
      end else if (!en) begin
         acc <= 33'h0_0000_0000;
      end else if (tick) begin
         acc <= next_acc - ivl;
      end else begin
         acc <= next_acc;
      end
   end
endmodule

// File: hw/pae_top.sv
// Purpose: pattern sequencer with primary/secondary alternation and bit error injection
// Assumes: classic Wishbone slave, single mclk, err_in and aux_in asynchronous to mclk
// Notes: pattern lengths in 512-bit units so every pattern end is a chunk boundary
`timescale 1ns/1ps
module pae_top
   import pae_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic err_in,
   input wire logic aux_in,
   output logic [WORD_W-1:0] data_out,
   output logic [WORD_W-1:0] aux_out,
   output logic out_valid
);
   pae_ctrl_s ctrl;
   logic [2:0] rate_idx;
   logic [31:0] avg_bits;
   logic [7:0] half_len;
   logic [MEM_AW-1:0] maddr;
   logic [WORD_W-1:0] mem [MEM_WORDS];
   logic [WORD_W-1:0] mem_q;
   logic wr_acc, rd_acc, cmd_err, cmd_ins;
   logic [15:0] err_count;
   logic err_s1, err_s2, err_d, aux_s1, aux_s2, aux_d;
   logic err_edge, aux_edge;
   logic [MEM_AW-1:0] wptr, last_w, half_words, rd_addr;
   logic cur_b, next_b, pat_end, chunk_end, blank;
   logic edge_pend, shot_pend, man_pend, auto_pend, tick;
   logic [1:0] blk_w;
   logic [6:0] pos_ctr, pos_q, pos_now;
   logic arm_q, arm_now;
   logic [WORD_W-1:0] flip_mask;
   pae_stage_s st1;
   logic [31:0] interval;

   // wishbone strobes
   assign wr_acc = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
   assign rd_acc = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
   assign cmd_err = wr_acc && (wb_adr_i == REG_CMD) && wb_sel_i[0] && wb_dat_i[0];
   assign cmd_ins = wr_acc && (wb_adr_i == REG_CMD) && wb_sel_i[0] && wb_dat_i[1];

   // ack one cycle after request, dropped the cycle after
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      end
   end

   // configuration registers, byte lane writes
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl <= '0;
         rate_idx <= 3'h0;
         avg_bits <= AVG_RST;
         half_len <= LEN_RST;
      end else if (wr_acc) begin
         if (wb_adr_i == REG_CTRL) begin
            if (wb_sel_i[0]) ctrl[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1]) ctrl[11:8] <= wb_dat_i[11:8];
         end
         if (wb_adr_i == REG_RATE && wb_sel_i[0]) rate_idx <= wb_dat_i[2:0];
         if (wb_adr_i == REG_AVG) begin
            for (int i = 0; i < 4; i++) begin
               if (wb_sel_i[i]) avg_bits[i*8 +: 8] <= wb_dat_i[i*8 +: 8];
            end
         end
         if (wb_adr_i == REG_LEN && wb_sel_i[0]) half_len <= wb_dat_i[7:0];
      end
   end

   // pattern memory load port, address auto-increments on data write
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         maddr <= '0;
      end else if (wr_acc && wb_adr_i == REG_MADDR) begin
         maddr <= wb_dat_i[MEM_AW-1:0];
      end else if (wr_acc && wb_adr_i == REG_MDATA) begin
         maddr <= maddr + 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (wr_acc && wb_adr_i == REG_MDATA) mem[maddr] <= wb_dat_i;
      mem_q <= mem[rd_addr];
   end

   // read mux, unmapped reads return zero
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (rd_acc) begin
         case (wb_adr_i)
            REG_CTRL: wb_dat_o <= ctrl;
            REG_RATE: wb_dat_o <= {29'h0, rate_idx};
            REG_AVG: wb_dat_o <= avg_bits;
            REG_LEN: wb_dat_o <= {24'h0, half_len};
            REG_MADDR: wb_dat_o <= {20'h0, maddr};
            REG_STAT: wb_dat_o <= {err_count, 12'h0, man_pend | auto_pend, blank, cur_b, 1'b0};
            default: wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end

   // two-flop synchronisers, then edge detect on the second stage
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         err_s1 <= 1'b0;
         err_s2 <= 1'b0;
         err_d <= 1'b0;
         aux_s1 <= 1'b0;
         aux_s2 <= 1'b0;
         aux_d <= 1'b0;
      end else begin
         err_s1 <= err_in;
         err_s2 <= err_s1;
         err_d <= err_s2;
         aux_s1 <= aux_in;
         aux_s2 <= aux_s1;
         aux_d <= aux_s2;
      end
   end
   assign err_edge = err_s2 && !err_d;
   assign aux_edge = aux_s2 && !aux_d;

   // internal rate source, interval is preset or average bit count
   assign interval = ctrl.rate_avg ? avg_bits : preset_interval(rate_idx);

   pae_rate_gen u_rate (
      .mclk(mclk),
      .rst_b(rst_b),
      .en(ctrl.out_en && ctrl.src == SRC_INT),
      .interval(interval),
      .tick(tick)
   );

   // pattern geometry: halves of equal length, standard uses both
   always_comb begin
      half_words = MEM_AW'(half_len == 8'h00 ? 8'h01 : half_len) << CHUNK_WORDS_LOG2;
      last_w = ctrl.alt_pattern ? half_words - 1'b1 : (half_words << 1) - 1'b1;
      rd_addr = (ctrl.alt_pattern && cur_b) ? half_words + wptr : wptr;
      pat_end = ctrl.out_en && (wptr == last_w);
      chunk_end = ctrl.out_en && (wptr[3:0] == 4'hf);
   end

   // choice of the next pattern, taken only at a pattern end
   always_comb begin
      next_b = 1'b0;
      if (ctrl.alt_pattern) begin
         unique case (ctrl.aux_mode)
            AUX_LEVEL: next_b = aux_s2;
            AUX_EDGE: next_b = !cur_b && edge_pend;
            AUX_BLANK: next_b = 1'b0;
            AUX_DISABLE: begin
               unique case (ctrl.seq_mode)
                  SEQ_CONT_A: next_b = 1'b0;
                  SEQ_CONT_B: next_b = 1'b1;
                  SEQ_ALT: next_b = !cur_b;
                  SEQ_SHOT_B: next_b = !cur_b && shot_pend;
               endcase
            end
         endcase
      end
   end

   // word pointer and current half
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         wptr <= '0;
         cur_b <= 1'b0;
      end else if (!ctrl.out_en) begin
         wptr <= '0;
         // continuous secondary starts on the secondary half
         cur_b <= ctrl.alt_pattern && ctrl.aux_mode == AUX_DISABLE &&
            ctrl.seq_mode == SEQ_CONT_B;
      end else if (pat_end) begin
         wptr <= '0;
         cur_b <= next_b;
      end else begin
         wptr <= wptr + 1'b1;
      end
   end

   // blanking follows the control level at chunk boundaries
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         blank <= 1'b0;
      end else if (ctrl.aux_mode != AUX_BLANK) begin
         blank <= 1'b0;
      end else if (chunk_end) begin
         blank <= aux_s2;
      end
   end

   // insert requests, set wins over consume
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         edge_pend <= 1'b0;
         shot_pend <= 1'b0;
      end else begin
         edge_pend <= (ctrl.aux_mode == AUX_EDGE) && (aux_edge ||
            (edge_pend && !(pat_end && next_b)));
         shot_pend <= (ctrl.aux_mode == AUX_DISABLE) && (ctrl.seq_mode == SEQ_SHOT_B) &&
            ctrl.alt_pattern && (cmd_ins || (shot_pend && !(pat_end && next_b)));
      end
   end

   // error requests, consumed at the first word of each 128-bit block
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         man_pend <= 1'b0;
         auto_pend <= 1'b0;
      end else begin
         man_pend <= cmd_err || (man_pend && !(ctrl.out_en && blk_w == 2'b00));
         auto_pend <= (ctrl.src == SRC_EXT && err_edge) || (ctrl.src == SRC_INT && tick) ||
            (auto_pend && ctrl.src != SRC_OFF && !(ctrl.out_en && blk_w == 2'b00));
      end
   end

   // block word counter, error arm and flip position
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         blk_w <= 2'b00;
         pos_ctr <= 7'h00;
         pos_q <= 7'h00;
         arm_q <= 1'b0;
      end else begin
         pos_ctr <= pos_ctr + 7'h25;
         if (ctrl.out_en) begin
            blk_w <= blk_w + 2'b01;
            arm_q <= arm_now;
            pos_q <= pos_now;
         end else begin
            blk_w <= 2'b00;
         end
      end
   end

   // one flip per block, placed at pos_now within it
   always_comb begin
      arm_now = (blk_w == 2'b00) ? (man_pend || auto_pend) : arm_q;
      pos_now = (blk_w == 2'b00) ? pos_ctr : pos_q;
      flip_mask = '0;
      if (arm_now && blk_w == pos_now[6:5]) flip_mask[pos_now[4:0]] = 1'b1;
   end

   // first stream stage travels with the memory read
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         st1 <= '0;
         err_count <= 16'h0000;
      end else begin
         st1.valid <= ctrl.out_en;
         st1.blank <= blank;
         st1.flip <= ctrl.out_en ? flip_mask : '0;
         if (ctrl.out_en && flip_mask != '0) err_count <= err_count + 16'h0001;
      end
   end

   // output stage, channel routing of the flip
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         data_out <= '0;
         aux_out <= '0;
         out_valid <= 1'b0;
      end else begin
         out_valid <= st1.valid && !st1.blank;
         if (!st1.valid || st1.blank) begin
            data_out <= '0;
            aux_out <= '0;
         end else begin
            data_out <= mem_q ^ ((ctrl.chan != CH_AUX || ctrl.single_ch) ? st1.flip : '0);
            aux_out <= mem_q ^ ((ctrl.chan != CH_DATA && !ctrl.single_ch) ? st1.flip : '0);
         end
      end
   end

   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   ext_edge_sets_a: assert property ((ctrl.src == SRC_EXT && err_edge) |=> auto_pend)
      else $error("external edge did not raise an error request");
   off_ignores_a: assert property ((ctrl.src == SRC_OFF && !auto_pend) |=> !auto_pend)
      else $error("auto error request while source is off");
   one_per_block_a: assert property ((flip_mask != '0 && blk_w != 2'b11 && ctrl.out_en)
      |=> flip_mask == '0)
      else $error("second flip inside one block");
   single_bit_a: assert property ($onehot0(flip_mask))
      else $error("more than one bit flipped");
   cont_b_a: assert property ((ctrl.alt_pattern && ctrl.aux_mode == AUX_DISABLE &&
      ctrl.seq_mode == SEQ_CONT_B && pat_end) |=> cur_b)
      else $error("continuous secondary left the secondary half");
   alt_turn_a: assert property ((ctrl.alt_pattern && ctrl.aux_mode == AUX_DISABLE &&
      ctrl.seq_mode == SEQ_ALT && pat_end) |=> cur_b != $past(cur_b))
      else $error("alternate mode did not switch halves");
   shot_gate_a: assert property ((ctrl.seq_mode != SEQ_SHOT_B) |=> !shot_pend)
      else $error("insert request held outside single-shot mode");
   blank_no_b_a: assert property ((ctrl.aux_mode == AUX_BLANK && pat_end) |=> !cur_b)
      else $error("secondary sent in blanking mode");
   blank_step_a: assert property ((ctrl.aux_mode == AUX_BLANK && !chunk_end) |=> $stable(blank))
      else $error("blanking changed off a chunk boundary");
   std_no_b_a: assert property ((!ctrl.alt_pattern && pat_end) |=> !cur_b)
      else $error("sequencing active without alternating pattern");
   blank_quiet_a: assert property (st1.blank |=> !out_valid && data_out == '0)
      else $error("data sent while blanked");

   cov_err_c: cover property (ctrl.out_en && flip_mask != '0);
   cov_shot_c: cover property (shot_pend ##[1:300] cur_b);
   cov_edge_c: cover property (ctrl.aux_mode == AUX_EDGE && aux_edge ##[1:300] cur_b);
   cov_blank_c: cover property (st1.blank && st1.valid);
endmodule

// File: verif/pae_sink_model.sv
// Purpose: receiving end of the serial stream, tallies what arrives
// Assumes: both pattern halves are 16 words, stream may restart on any word
// Notes: each word is matched to the nearest stored word, flips are bit differences
`timescale 1ns/1ps
module pae_sink_model
   import pae_pkg::*;
(
   input wire logic mclk,
   input wire logic clr,
   input wire logic valid,
   input wire logic [WORD_W-1:0] data,
   input wire logic [WORD_W-1:0] aux,
   input wire logic [WORD_W-1:0] pat [0:31],
   output int nvalid,
   output int nsec,
   output int nflip,
   output int naux
);
   // class each valid word as primary or secondary, count flipped bits
   always @(posedge mclk) begin
      int d;
      int best;
      int bi;
      if (clr) begin
         nvalid = 0;
         nsec = 0;
         nflip = 0;
         naux = 0;
      end else if (valid === 1'b1) begin
         best = WORD_W + 1;
         bi = 0;
         // position free, so blanked gaps and mid-stream clears keep alignment
         for (int i = 0; i < 32; i++) begin
            d = $countones(data ^ pat[i]);
            if (d < best) begin
               best = d;
               bi = i;
            end
         end
         nsec += (bi >= 16) ? 1 : 0;
         nflip += best;
         naux += $countones(aux ^ pat[bi]);
         nvalid++;
      end
   end
endmodule

// File: verif/pae_top_tb_top.sv
// Purpose: self-checking bench for the pattern sequencer with error injection
// Assumes: half length of one 512-bit unit, classic Wishbone register access
// Notes: random pattern words and pulse counts from a fixed seed
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin miscompares++; \
   $display("Error at %0t: got %0h expected %0h", $time, a, b); end end
module pae_top_tb_top
   import pae_pkg::*;
;
   logic mclk, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, err_in, aux_in, out_valid, clr;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, q;
   logic [WORD_W-1:0] data_out, aux_out;
   logic [WORD_W-1:0] pat [0:31];
   int nvalid, nsec, nflip, naux, miscompares, samples_checked, seed, n;

   pae_top uut (.mclk(mclk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .err_in(err_in), .aux_in(aux_in),
      .data_out(data_out), .aux_out(aux_out), .out_valid(out_valid));
   pae_sink_model sink (.mclk(mclk), .clr(clr), .valid(out_valid), .data(data_out),
      .aux(aux_out), .pat(pat), .nvalid(nvalid), .nsec(nsec), .nflip(nflip), .naux(naux));

   // clock generator
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   // one classic Wishbone cycle, held until ack is sampled
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
      int t;
      t = 0;
      @(posedge mclk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= d;
      do begin
         @(posedge mclk);
         t++;
      end while (wb_ack_o !== 1'b1 && t < 50);
      if (t >= 50) miscompares++;
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   task automatic wt(input int c);
      repeat (c) @(posedge mclk);
   endtask

   // restart the stream with a fresh tally
   task automatic start(input logic [31:0] c);
      clr <= 1'b1;
      wb(1'b1, REG_CTRL, c & 32'hffff_fffe);
      wb(1'b1, REG_CTRL, c);
      clr <= 1'b0;
   endtask

   task automatic clear();
      clr <= 1'b1;
      wt(1);
      clr <= 1'b0;
   endtask

   // rising edges on the error input, each in its own 128-bit block
   task automatic pulse_err(input int k);
      repeat (k) begin
         err_in <= 1'b1;
         wt(3);
         err_in <= 1'b0;
         wt(10 + ($random(seed) & 7));
      end
   endtask

   function automatic logic [31:0] cf(pae_aux_e a, pae_seq_e s, logic alt, logic sg,
      pae_chan_e c, logic ra, pae_src_e src);
      pae_ctrl_s x;
      x = '0;
      x.aux_mode = a;
      x.seq_mode = s;
      x.alt_pattern = alt;
      x.single_ch = sg;
      x.chan = c;
      x.rate_avg = ra;
      x.src = src;
      x.out_en = 1'b1;
      return x;
   endfunction

   // expected error count over nv words for a given bit interval
   function automatic int exp_flips(input int nv, input int interval);
      return nv * 32 / interval;
   endfunction

   function automatic logic near(input int a, input int b, input int tol);
      return (a - b <= tol) && (b - a <= tol);
   endfunction

   task automatic print_verdict();
      $display("checks %0d, mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // watchdog against a hung handshake or stream
   initial begin
      #100000;
      miscompares++;
      print_verdict();
   end

   // main sequence
   initial begin
      seed = 49214;
      {rst_b, wb_cyc_i, wb_stb_i, wb_we_i, err_in, aux_in, clr} = '0;
      {wb_adr_i, wb_dat_i, miscompares, samples_checked} = '0;
      wb_sel_i = 4'hf;
      wt(2);
      rst_b <= 1'b1;
      wt(1);
      `CHK({out_valid, data_out}, 33'h0)
      wb(1'b0, REG_CTRL, 32'h0);
      `CHK(q, 32'h0)
      wb(1'b0, REG_AVG, 32'h0);
      `CHK(q, AVG_RST)
      wb(1'b0, REG_LEN, 32'h0);
      `CHK(q[7:0], LEN_RST)
      wb(1'b0, 8'h40, 32'h0);
      `CHK(q, 32'h0)
      wb(1'b1, REG_MADDR, 32'h0);
      for (int i = 0; i < 32; i++) begin
         pat[i] = $random(seed);
         wb(1'b1, REG_MDATA, pat[i]);
      end
      start(cf(AUX_DISABLE, SEQ_CONT_B, 1'b0, 1'b0, CH_DATA, 1'b0, SRC_OFF));
      wt(128);
      `CHK(nflip, 0)
      `CHK(nvalid > 110, 1'b1)
      `CHK(near(nvalid, 2 * nsec, 16), 1'b1)
      for (int s = 0; s < 3; s++) begin
         start(cf(AUX_DISABLE, pae_seq_e'(s), 1'b1, 1'b0, CH_DATA, 1'b0, SRC_OFF));
         wt(128);
         `CHK(near(nsec, (s == 0) ? 0 : (s == 1) ? nvalid : nvalid / 2, (s == 2) ? 16 : 0),
            1'b1)
      end
      start(cf(AUX_DISABLE, SEQ_CONT_A, 1'b1, 1'b0, CH_DATA, 1'b0, SRC_OFF));
      wb(1'b1, REG_CMD, 32'h2);
      wt(96);
      `CHK(nsec, 0)
      start(cf(AUX_DISABLE, SEQ_SHOT_B, 1'b1, 1'b0, CH_DATA, 1'b0, SRC_OFF));
      wb(1'b1, REG_CMD, 32'h2);
      wt(96);
      `CHK(nsec, 16)
      aux_in <= 1'b1;
      start(cf(AUX_DISABLE, SEQ_CONT_A, 1'b1, 1'b0, CH_DATA, 1'b0, SRC_OFF));
      wt(96);
      `CHK(nsec, 0)
      start(cf(AUX_LEVEL, SEQ_CONT_A, 1'b1, 1'b0, CH_DATA, 1'b0, SRC_OFF));
      wt(64);
      clear();
      wt(48);
      `CHK(nsec === nvalid && nvalid > 0, 1'b1)
      aux_in <= 1'b0;
      wt(48);
      clear();
      wt(48);
      `CHK(nsec, 0)
      start(cf(AUX_EDGE, SEQ_CONT_A, 1'b1, 1'b0, CH_DATA, 1'b0, SRC_OFF));
      wt(20);
      aux_in <= 1'b1;
      wt(5);
      aux_in <= 1'b0;
      wt(128);
      `CHK(nsec, 16)
      for (int a = 1; a >= 0; a--) begin
         aux_in <= 1'b1;
         start(cf(AUX_BLANK, SEQ_CONT_B, a[0], 1'b0, CH_DATA, 1'b0, SRC_OFF));
         wt(48);
         clear();
         wt(48);
         `CHK(nvalid, 0)
         aux_in <= 1'b0;
         wt(48);
         clear();
         wt(48);
         `CHK(nvalid > 0 && (a == 0 || nsec == 0), 1'b1)
      end
      start(cf(AUX_DISABLE, SEQ_CONT_A, 1'b1, 1'b0, CH_DATA, 1'b0, SRC_OFF));
      pulse_err(3);
      wb(1'b1, REG_CMD, 32'h1);
      wt(32);
      `CHK(nflip, 1)
      `CHK(naux, 0)
      n = 1 + ($random(seed) & 3);
      start(cf(AUX_DISABLE, SEQ_CONT_A, 1'b1, 1'b0, CH_DATA, 1'b0, SRC_EXT));
      pulse_err(n);
      wt(16);
      `CHK(nflip, n)
      for (int sg = 0; sg < 2; sg++) begin
         start(cf(AUX_DISABLE, SEQ_CONT_A, 1'b1, sg[0], CH_AUX, 1'b0, SRC_EXT));
         pulse_err(2);
         wt(16);
         `CHK({nflip, naux}, (sg == 1) ? {32'd2, 32'd0} : {32'd0, 32'd2})
      end
      start(cf(AUX_DISABLE, SEQ_CONT_A, 1'b1, 1'b0, CH_DATA, 1'b0, SRC_EXT));
      wb(1'b1, REG_CMD, 32'h1);
      wt(16);
      `CHK(nflip, 1)
      wb(1'b1, REG_AVG, 32'd400);
      start(cf(AUX_DISABLE, SEQ_CONT_A, 1'b1, 1'b0, CH_DATA, 1'b1, SRC_INT));
      wt(640);
      `CHK(near(nflip, exp_flips(nvalid, 400), 3), 1'b1)
      wb(1'b1, REG_RATE, 32'h1);
      start(cf(AUX_DISABLE, SEQ_CONT_A, 1'b1, 1'b0, CH_DATA, 1'b0, SRC_INT));
      wt(640);
      `CHK(near(nflip, exp_flips(nvalid, 1000), 2), 1'b1)
      print_verdict();
   end
endmodule
